// File: hw/rtq_pkg.sv
// Package with constants, register map and types of the runt trigger qualifier.
package rtq_pkg;
    localparam int SAMPLE_W = 12;
    localparam int TIME_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_HIGH_THR = 4'h1;
    localparam logic [3:0] OFF_LOW_THR = 4'h2;
    localparam logic [3:0] OFF_TRIG_LVL = 4'h3;
    localparam logic [3:0] OFF_QUIET = 4'h4;
    localparam logic [3:0] OFF_TIME_LOW = 4'h5;
    localparam logic [3:0] OFF_TIME_HIGH = 4'h6;
    localparam logic [3:0] OFF_STATUS = 4'h7;
    localparam logic [3:0] OFF_INT_STAT = 4'h8;
    localparam logic [3:0] OFF_INT_MASK = 4'h9;
    localparam logic [3:0] OFF_LAST_TIME = 4'ha;
    localparam int CTRL_POL_LSB = 0;
    localparam int CTRL_TCOND_LSB = 2;
    localparam int CTRL_TDC_BIT = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [11:0] HIGH_THR_RST = 12'hc00;
    localparam logic [11:0] LOW_THR_RST = 12'h400;
    localparam logic [11:0] TRIG_LVL_RST = 12'h800;
    localparam logic [15:0] QUIET_RST = 16'h0000;
    localparam logic [15:0] TIME_LOW_RST = 16'h0000;
    localparam logic [15:0] TIME_HIGH_RST = 16'hffff;
    localparam logic [1:0] INT_RST = 2'h0;
    localparam int INT_TRIG_BIT = 0;
    localparam int INT_ARM_BIT = 1;
    localparam logic [1:0] POL_POSITIVE = 2'h0;
    localparam logic [1:0] POL_NEGATIVE = 2'h1;
    localparam logic [1:0] POL_EITHER = 2'h2;
    localparam logic [1:0] TC_NONE = 2'h0;
    localparam logic [1:0] TC_INSIDE = 2'h1;
    localparam logic [1:0] TC_OUTSIDE = 2'h2;
    localparam int TDC_FRAC_W = 4;
    typedef enum logic [1:0] {RTQ_QUIET, RTQ_ARMED} rtq_arm_t;
    typedef enum logic [1:0] {RTQ_IDLE, RTQ_INPULSE, RTQ_VOID} rtq_pulse_t;
endpackage

// File: hw/rtq_pulse_det.sv
// One-polarity runt pulse detector with duration measurement.
`timescale 1ns/10ps
module rtq_pulse_det (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic clr,
    input wire logic enter_band,
    input wire logic exit_back,
    input wire logic cross_far,
    output logic det,
    output logic [rtq_pkg::TIME_W-1:0] dur
);
    rtq_pkg::rtq_pulse_t st_r;
    logic [rtq_pkg::TIME_W-1:0] cnt_r;
    logic det_r;
    logic [rtq_pkg::TIME_W-1:0] dur_r;
    wire cnt_max = (cnt_r == {rtq_pkg::TIME_W{1'b1}});
    wire ends = (st_r == rtq_pkg::RTQ_INPULSE) && exit_back && !cross_far;
    assign det = det_r;
    assign dur = dur_r;
    // A pulse that reaches the far bound is no runt; wait for it to come back before rearming.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_r <= rtq_pkg::RTQ_IDLE;
            cnt_r <= '0;
            det_r <= 1'b0;
            dur_r <= '0;
        end else if (ce) begin
            det_r <= ends && !clr;
            if (ends) begin
                dur_r <= cnt_r;
            end
            if (clr) begin
                st_r <= rtq_pkg::RTQ_IDLE;
            end else begin
                case (st_r)
                    rtq_pkg::RTQ_IDLE: begin
                        if (enter_band) begin
                            st_r <= rtq_pkg::RTQ_INPULSE;
                            cnt_r <= 16'h0001;
                        end
                    end
                    rtq_pkg::RTQ_INPULSE: begin
                        if (cross_far) begin
                            st_r <= rtq_pkg::RTQ_VOID;
                        end else if (exit_back) begin
                            st_r <= rtq_pkg::RTQ_IDLE;
                        end else if (!cnt_max) begin
                            cnt_r <= cnt_r + 16'h0001;
                        end
                    end
                    rtq_pkg::RTQ_VOID: begin
                        if (exit_back) begin
                            st_r <= rtq_pkg::RTQ_IDLE;
                        end
                    end
                    default: st_r <= rtq_pkg::RTQ_IDLE;
                endcase
            end
        end
    end
endmodule

// File: hw/rtq_top.sv
// Runt trigger qualifier: arming, runt detection, time qualification and registers.
// Operation
// - Arm only after full quiet interval below level.
// - Hold programmable upper voltage bound.
// - Hold programmable lower voltage bound.
// - Polarity select: positive, negative or either.
// - Positive: rise, fall through low, no high.
// - Negative: fall, rise through high, no low.
// - Either polarity fires on both runt kinds.
// - Optional duration qualification by time condition.
// - Refine trigger time only when enabled.
// - Trigger available as output for other triggers.
// - Low time limit bounds duration from below.
// - High time limit bounds duration from above.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
module rtq_top (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [rtq_pkg::SAMPLE_W-1:0] sample,
    input wire logic [rtq_pkg::TDC_FRAC_W-1:0] tdc_frac,
    input wire logic [rtq_pkg::ADDR_W-1:0] addr,
    input wire logic [rtq_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [rtq_pkg::DATA_W-1:0] rdata,
    output logic ref_trig,
    output logic armed,
    output logic irq
);
    logic [4:0] ctrl_r;
    logic [rtq_pkg::SAMPLE_W-1:0] high_thr_r;
    logic [rtq_pkg::SAMPLE_W-1:0] low_thr_r;
    logic [rtq_pkg::SAMPLE_W-1:0] trig_lvl_r;
    logic [rtq_pkg::TIME_W-1:0] quiet_r;
    logic [rtq_pkg::TIME_W-1:0] time_low_r;
    logic [rtq_pkg::TIME_W-1:0] time_high_r;
    logic [1:0] int_stat_r;
    logic [1:0] int_mask_r;
    logic [rtq_pkg::DATA_W-1:0] rdata_r;
    logic [rtq_pkg::SAMPLE_W-1:0] prev_r;
    logic prev_ok_r;
    rtq_pkg::rtq_arm_t arm_r;
    logic [rtq_pkg::TIME_W-1:0] quiet_cnt_r;
    logic trig_r;
    logic [rtq_pkg::TIME_W+rtq_pkg::TDC_FRAC_W-1:0] trig_time_r;
    logic [rtq_pkg::TIME_W-1:0] ts_r;

    wire [1:0] pol = ctrl_r[rtq_pkg::CTRL_POL_LSB +: 2];
    wire [1:0] tcond = ctrl_r[rtq_pkg::CTRL_TCOND_LSB +: 2];
    wire tdc_en = ctrl_r[rtq_pkg::CTRL_TDC_BIT];

    // Threshold crossings between the previous and current sample.
    wire was_above_low = prev_r > low_thr_r;
    wire is_above_low = sample > low_thr_r;
    wire was_below_high = prev_r < high_thr_r;
    wire is_below_high = sample < high_thr_r;
    wire rise_low = prev_ok_r && !was_above_low && is_above_low;
    wire fall_low = prev_ok_r && was_above_low && !is_above_low;
    wire fall_high = prev_ok_r && !was_below_high && is_below_high;
    wire rise_high = prev_ok_r && was_below_high && !is_below_high;
    wire reach_high = sample >= high_thr_r;
    wire reach_low = sample <= low_thr_r;

    wire pos_en = (pol == rtq_pkg::POL_POSITIVE) || (pol == rtq_pkg::POL_EITHER);
    wire neg_en = (pol == rtq_pkg::POL_NEGATIVE) || (pol == rtq_pkg::POL_EITHER);
    wire is_armed = (arm_r == rtq_pkg::RTQ_ARMED);
    wire det_clr = !is_armed;

    logic pos_det;
    logic neg_det;
    logic [rtq_pkg::TIME_W-1:0] pos_dur;
    logic [rtq_pkg::TIME_W-1:0] neg_dur;

    rtq_pulse_det u_pos (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .clr(det_clr || !pos_en),
        .enter_band(rise_low && !reach_high),
        .exit_back(fall_low),
        .cross_far(reach_high),
        .det(pos_det),
        .dur(pos_dur)
    );

    rtq_pulse_det u_neg (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .clr(det_clr || !neg_en),
        .enter_band(fall_high && !reach_low),
        .exit_back(rise_high),
        .cross_far(reach_low),
        .det(neg_det),
        .dur(neg_dur)
    );

    wire [rtq_pkg::TIME_W-1:0] pdur = pos_det ? pos_dur : neg_dur;
    wire in_win = (pdur >= time_low_r) && (pdur <= time_high_r);
    wire time_ok = (tcond == rtq_pkg::TC_NONE) ? 1'b1 :
                   (tcond == rtq_pkg::TC_INSIDE) ? in_win :
                   (tcond == rtq_pkg::TC_OUTSIDE) ? !in_win : 1'b1;
    wire fire = is_armed && (pos_det || neg_det) && time_ok;

    wire loud = sample > trig_lvl_r;
    wire quiet_done = !loud && (quiet_cnt_r >= quiet_r);

    // Register decode.
    wire wr_ctrl = wr && (addr == rtq_pkg::OFF_CTRL);
    wire wr_high = wr && (addr == rtq_pkg::OFF_HIGH_THR);
    wire wr_low = wr && (addr == rtq_pkg::OFF_LOW_THR);
    wire wr_lvl = wr && (addr == rtq_pkg::OFF_TRIG_LVL);
    wire wr_quiet = wr && (addr == rtq_pkg::OFF_QUIET);
    wire wr_tlow = wr && (addr == rtq_pkg::OFF_TIME_LOW);
    wire wr_thigh = wr && (addr == rtq_pkg::OFF_TIME_HIGH);
    wire wr_istat = wr && (addr == rtq_pkg::OFF_INT_STAT);
    wire wr_imask = wr && (addr == rtq_pkg::OFF_INT_MASK);
    wire [1:0] int_evt = {ce && is_armed == 1'b0 && quiet_done, ce && fire};
    wire [1:0] int_clr = wr_istat ? wdata[1:0] : 2'h0;
    wire [1:0] int_stat_nxt = (int_stat_r & ~int_clr) | int_evt;

    logic [rtq_pkg::DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        case (addr)
            rtq_pkg::OFF_CTRL: rd_mux = {27'h0, ctrl_r};
            rtq_pkg::OFF_HIGH_THR: rd_mux = {20'h0, high_thr_r};
            rtq_pkg::OFF_LOW_THR: rd_mux = {20'h0, low_thr_r};
            rtq_pkg::OFF_TRIG_LVL: rd_mux = {20'h0, trig_lvl_r};
            rtq_pkg::OFF_QUIET: rd_mux = {16'h0, quiet_r};
            rtq_pkg::OFF_TIME_LOW: rd_mux = {16'h0, time_low_r};
            rtq_pkg::OFF_TIME_HIGH: rd_mux = {16'h0, time_high_r};
            rtq_pkg::OFF_STATUS: rd_mux = {30'h0, trig_r, is_armed};
            rtq_pkg::OFF_INT_STAT: rd_mux = {30'h0, int_stat_r};
            rtq_pkg::OFF_INT_MASK: rd_mux = {30'h0, int_mask_r};
            rtq_pkg::OFF_LAST_TIME: rd_mux = {12'h0, trig_time_r};
            default: rd_mux = '0;
        endcase
    end

    assign rdata = rdata_r;
    assign ref_trig = trig_r;
    assign armed = is_armed;
    assign irq = |(int_stat_r & int_mask_r);

    // Configuration registers; a write is ignored while the clock enable is low.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= rtq_pkg::CTRL_RST;
            high_thr_r <= rtq_pkg::HIGH_THR_RST;
            low_thr_r <= rtq_pkg::LOW_THR_RST;
            trig_lvl_r <= rtq_pkg::TRIG_LVL_RST;
            quiet_r <= rtq_pkg::QUIET_RST;
            time_low_r <= rtq_pkg::TIME_LOW_RST;
            time_high_r <= rtq_pkg::TIME_HIGH_RST;
            int_mask_r <= rtq_pkg::INT_RST;
        end else if (ce) begin
            if (wr_ctrl) ctrl_r <= wdata[4:0];
            if (wr_high) high_thr_r <= wdata[11:0];
            if (wr_low) low_thr_r <= wdata[11:0];
            if (wr_lvl) trig_lvl_r <= wdata[11:0];
            if (wr_quiet) quiet_r <= wdata[15:0];
            if (wr_tlow) time_low_r <= wdata[15:0];
            if (wr_thigh) time_high_r <= wdata[15:0];
            if (wr_imask) int_mask_r <= wdata[1:0];
        end
    end

    // Interrupt status: a new event wins over a clear in the same cycle.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            int_stat_r <= rtq_pkg::INT_RST;
            rdata_r <= '0;
        end else if (ce) begin
            int_stat_r <= int_stat_nxt;
            rdata_r <= rd ? rd_mux : '0;
        end
    end

    // Sample history.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prev_r <= '0;
            prev_ok_r <= 1'b0;
            ts_r <= '0;
        end else if (ce) begin
            prev_r <= sample;
            prev_ok_r <= 1'b1;
            ts_r <= ts_r + 16'h0001;
        end
    end

    // Arming: quiet interval, then armed until one trigger fires.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            arm_r <= rtq_pkg::RTQ_QUIET;
            quiet_cnt_r <= '0;
            trig_r <= 1'b0;
            trig_time_r <= '0;
        end else if (ce) begin
            trig_r <= fire;
            case (arm_r)
                rtq_pkg::RTQ_QUIET: begin
                    if (loud) begin
                        quiet_cnt_r <= '0;
                    end else if (quiet_done) begin
                        arm_r <= rtq_pkg::RTQ_ARMED;
                    end else begin
                        quiet_cnt_r <= quiet_cnt_r + 16'h0001;
                    end
                end
                rtq_pkg::RTQ_ARMED: begin
                    if (fire) begin
                        arm_r <= rtq_pkg::RTQ_QUIET;
                        quiet_cnt_r <= '0;
                        trig_time_r <= {ts_r, tdc_en ? tdc_frac : 4'h0};
                    end
                end
                default: arm_r <= rtq_pkg::RTQ_QUIET;
            endcase
        end
    end
endmodule

// File: verification/rtq_properties.sv
// Port checker of the runt trigger qualifier.
`timescale 1ns/10ps
module rtq_checker (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [11:0] sample,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic ref_trig,
    input wire logic armed,
    input wire logic irq
);
    logic [11:0] lvl_r;
    logic [1:0] mask_r;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lvl_r <= 12'h800;
            mask_r <= 2'h0;
        end else if (ce && wr && addr == 4'h3) begin
            lvl_r <= wdata[11:0];
        end else if (ce && wr && addr == 4'h9) begin
            mask_r <= wdata[1:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    trig_single_a: assert property (ref_trig && ce |=> !ref_trig) else $error("trigger too long");
    trig_armed_a: assert property ($rose(ref_trig) |-> $past(armed)) else $error("trigger unarmed");
    trig_disarm_a: assert property (ref_trig |-> !armed) else $error("armed at trigger");
    quiet_hold_a: assert property (ce && !armed && sample > lvl_r |=> !armed) else $error("armed above level");
    arm_level_a: assert property ($rose(armed) |-> $past(sample) <= $past(lvl_r)) else $error("bad arm");
    rdata_idle_a: assert property (ce && !rd |=> rdata == 32'h0) else $error("read data not idle");
    status_arm_a: assert property (ce && rd && addr == 4'h7 |=> rdata[0] == $past(armed))
        else $error("status armed wrong");
    irq_mask_a: assert property (irq |-> mask_r != 2'h0) else $error("masked interrupt");
    trig_irq_a: assert property (ref_trig && ce && mask_r[0] |=> irq) else $error("no interrupt");
    reset_clear_a: assert property ($rose(nrst) |-> !armed && !ref_trig && !irq) else $error("reset state");
    cover property (ref_trig);
    cover property ($rose(armed));
    cover property (irq);
endmodule

// File: verification/rtq_adc_model.sv
// Converter model that slews its sample toward a target level.
`timescale 1ns/10ps
module rtq_adc_model (
    input wire logic clock,
    input wire logic [11:0] target,
    input wire logic [11:0] step,
    output logic [11:0] sample
);
    initial sample = 12'h000;
    always @(posedge clock) begin
        if (target > sample && target - sample > step) begin
            sample <= sample + step;
        end else if (target < sample && sample - target > step) begin
            sample <= sample - step;
        end else begin
            sample <= target;
        end
    end
endmodule

// File: verification/rtq_top_tb.sv
// Self-checking bench of the runt trigger qualifier.
`timescale 1ns/10ps
module rtq_top_tb;
    typedef struct {logic [4:0] ctl; logic [15:0] tlo; logic [15:0] thi; logic [11:0] rest;
        logic [11:0] peak; logic [11:0] stp; logic [7:0] w; logic exp;} rtq_row_t;
    logic clock, nrst, ce, wr, rd, ref_trig, armed, irq;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, v;
    logic [11:0] sample, tgt, stp;
    logic [7:0] n;
    int errors, check_count;
    logic [31:0] rv [7] = '{32'h0, 32'hc00, 32'h400, 32'h800, 32'h0, 32'h0, 32'hffff};
    rtq_row_t rows [14] = '{
        '{5'h10, 16'h0, 16'hffff, 12'h100, 12'h800, 12'hfff, 8'h5, 1'h1},
        '{5'h00, 16'h0, 16'hffff, 12'h100, 12'hd00, 12'h100, 8'h20, 1'h0},
        '{5'h01, 16'h0, 16'hffff, 12'he00, 12'h800, 12'hfff, 8'h5, 1'h1},
        '{5'h01, 16'h0, 16'hffff, 12'he00, 12'h100, 12'hfff, 8'h5, 1'h0},
        '{5'h01, 16'h0, 16'hffff, 12'h100, 12'h800, 12'hfff, 8'h5, 1'h0},
        '{5'h02, 16'h0, 16'hffff, 12'h100, 12'h800, 12'hfff, 8'h5, 1'h1},
        '{5'h02, 16'h0, 16'hffff, 12'he00, 12'h800, 12'hfff, 8'h5, 1'h1},
        '{5'h04, 16'h4, 16'h8, 12'h100, 12'h800, 12'hfff, 8'h3, 1'h0},
        '{5'h04, 16'h4, 16'h8, 12'h100, 12'h800, 12'hfff, 8'h4, 1'h1},
        '{5'h04, 16'h4, 16'h8, 12'h100, 12'h800, 12'hfff, 8'h8, 1'h1},
        '{5'h04, 16'h4, 16'h8, 12'h100, 12'h800, 12'hfff, 8'h9, 1'h0},
        '{5'h08, 16'h4, 16'h8, 12'h100, 12'h800, 12'hfff, 8'h6, 1'h0},
        '{5'h08, 16'h4, 16'h8, 12'h100, 12'h800, 12'hfff, 8'h9, 1'h1},
        '{5'h0c, 16'h4, 16'h8, 12'h100, 12'h800, 12'hfff, 8'h3, 1'h1}};
    rtq_adc_model adc (.clock, .target(tgt), .step(stp), .sample);
    rtq_top dut (.clock, .nrst, .ce, .sample, .tdc_frac(4'h9), .addr, .wdata, .wr, .rd, .rdata, .ref_trig, .armed, .irq);
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clock);
        wr <= 1'h0;
    endtask
    task rd_reg(input logic [3:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'h1;
        @(posedge clock);
        rd <= 1'h0;
        #1 v = rdata;
    endtask
    task wait_arm;
        for (n = 0; n < 8'h3c && armed !== 1'h1; n++) begin
            @(posedge clock);
            #1;
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        test_done();
    end
    initial begin
        {nrst, wr, rd, ce, addr, wdata, tgt, stp} = {4'h1, 4'h0, 32'h0, 12'h0, 12'hfff};
        repeat (16) @(posedge clock);
        nrst <= 1'h1;
        foreach (rv[i]) begin
            rd_reg(4'(i));
            chk("reset value", rv[i], v);
        end
        rd_reg(4'hf);
        chk("unmapped", 32'h0, v);
        $display("test reset done");
        wr_reg(4'h4, 32'h14);
        wr_reg(4'h9, 32'h1);
        wait_arm();
        @(posedge clock);
        tgt <= 12'h800;
        repeat (3) @(posedge clock);
        tgt <= 12'h0;
        repeat (6) @(posedge clock);
        tgt <= 12'h900;
        #1 chk("irq", 1, irq);
        chk("disarmed", 0, armed);
        repeat (5) @(posedge clock);
        tgt <= 12'h0;
        repeat (10) @(posedge clock);
        tgt <= 12'h900;
        @(posedge clock);
        tgt <= 12'h0;
        wait_arm();
        chk("quiet span", 1, n >= 8'h12 && n <= 8'h18);
        rd_reg(4'h7);
        chk("status", 1, v[0]);
        rd_reg(4'h8);
        chk("event", 1, v[0]);
        wr_reg(4'h8, 32'h1);
        @(posedge clock);
        #1 chk("irq clear", 0, irq);
        $display("test quiet done");
        wr_reg(4'h3, 32'hfff);
        wr_reg(4'h4, 32'h0);
        wr_reg(4'h9, 32'h0);
        foreach (rows[i]) begin
            @(posedge clock);
            stp <= 12'hfff;
            tgt <= rows[i].rest;
            repeat (20) @(posedge clock);
            wr_reg(4'h0, {27'h0, rows[i].ctl});
            wr_reg(4'h5, {16'h0, rows[i].tlo});
            wr_reg(4'h6, {16'h0, rows[i].thi});
            repeat (3) @(posedge clock);
            #1 chk("armed", 1, armed);
            @(posedge clock);
            stp <= rows[i].stp;
            tgt <= rows[i].peak;
            repeat (rows[i].w) @(posedge clock);
            tgt <= rows[i].rest;
            n = 0;
            repeat (40) begin
                @(posedge clock);
                #1 n += ref_trig;
            end
            chk("fires", rows[i].exp, n);
            if (rows[i].exp) begin
                rd_reg(4'ha);
                chk("fraction", rows[i].ctl[4] ? 32'h9 : 32'h0, v[3:0]);
            end
            $display("test row %0d done", i);
        end
        chk("masked irq", 0, irq);
        @(posedge clock);
        nrst <= 1'h0;
        #1 chk("reset armed", 0, armed);
        @(posedge clock);
        nrst <= 1'h1;
        rd_reg(4'h3);
        chk("level after reset", 32'h800, v);
        @(posedge clock);
        ce <= 1'h0;
        wr_reg(4'h4, 32'h5);
        ce <= 1'h1;
        rd_reg(4'h4);
        chk("frozen write", 32'h0, v);
        $display("test reset and enable done");
        test_done();
    end
endmodule
bind rtq_top rtq_checker chk_u (.clock, .nrst, .ce, .sample, .addr, .wdata, .wr, .rd, .rdata, .ref_trig, .armed, .irq);
